// ---- rtl/spi_config_status.v ----
// SPI configuration and status register with select deglitch and status tracking
`timescale 1ns/1ps
`include "spi_config_status_regs.vh"
module spi_config_status (
	input wire clk,
	input wire reset_n,
	input wire cfg_write,
	input wire [7:0] cfg_wdata,
	output reg [7:0] cfg_rdata,
	input wire port_enable_bit,
	input wire transfer_busy,
	input wire tx_load,
	input wire rx_byte_arrived,
	input wire rx_buffer_read,
	input wire slave_select_input,
	input wire sck_pin,
	output wire host_role_enable,
	output wire clock_phase_select,
	output wire clock_polarity_select,
	output wire sck_idle_level,
	output wire sample_on_rising,
	output wire selected_flag,
	output wire shifter_empty_flag,
	output wire rx_holding_empty_flag
);

	// ****************************************
	// Reset release
	// ****************************************
	reg rst_meta_r;
	reg rst_sync_r;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Bit 0 is the select pin, bit 1 the serial clock pin
	localparam [1:0] PIN_IDLE = `PIN_SYNC_IDLE;
	localparam [7:0] CFG_RESET = `CFG_RESET_VALUE;
	wire [1:0] pin_raw;
	reg [1:0] pin_meta_r;
	reg [1:0] pin_sync_r;
	assign pin_raw = {sck_pin, slave_select_input};
	genvar pin_i;
	generate
		for (pin_i = 0; pin_i < 2; pin_i = pin_i + 1) begin : g_pin_sync
			// Idle reset levels keep a false edge or select from following reset
			always @(posedge clk or negedge rst_sync_r) begin
				if (!rst_sync_r) begin
					pin_meta_r[pin_i] <= PIN_IDLE[pin_i];
					pin_sync_r[pin_i] <= PIN_IDLE[pin_i];
				end else begin
					pin_meta_r[pin_i] <= pin_raw[pin_i];
					pin_sync_r[pin_i] <= pin_meta_r[pin_i];
				end
			end
		end
	endgenerate
	wire nss_sync;
	wire sck_sync;
	assign nss_sync = pin_sync_r[0];
	assign sck_sync = pin_sync_r[1];

	// ****************************************
	// Serial clock edge detect
	// ****************************************
	reg sck_prev_r;
	always @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			sck_prev_r <= PIN_IDLE[1];
		end else begin
			sck_prev_r <= sck_sync;
		end
	end
	// Both directions count: any transition while port_enable_bit is set means the shifter is in use
	wire sck_edge;
	assign sck_edge = sck_sync ^ sck_prev_r;

	// ****************************************
	// Select deglitch
	// ****************************************
	// A level must hold for one cycle more than the filter count before the flag follows it
	reg [1:0] glitch_cnt_r;
	reg [1:0] glitch_cnt_nxt;
	reg selected_r;
	reg selected_nxt;
	always @* begin
		glitch_cnt_nxt = 2'h0;
		selected_nxt = selected_r;
		if (nss_sync == selected_r) begin
			if (glitch_cnt_r == `GLITCH_FILTER_CYCLES) begin
				selected_nxt = ~nss_sync;
			end else begin
				glitch_cnt_nxt = glitch_cnt_r + 2'h1;
			end
		end
	end
	always @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			glitch_cnt_r <= 2'h0;
			selected_r <= CFG_RESET[`CFG_BIT_SELECTED];
		end else begin
			glitch_cnt_r <= glitch_cnt_nxt;
			selected_r <= selected_nxt;
		end
	end
	assign selected_flag = selected_r;

	// ****************************************
	// Writable configuration
	// ****************************************
	reg host_r;
	reg phase_r;
	reg polarity_r;
	reg host_nxt;
	reg phase_nxt;
	reg polarity_nxt;
	always @* begin
		host_nxt = host_r;
		phase_nxt = phase_r;
		polarity_nxt = polarity_r;
		if (cfg_write) begin
			// Selected and live-pin positions have no storage behind them
			host_nxt = cfg_wdata[`CFG_BIT_HOST];
			phase_nxt = cfg_wdata[`CFG_BIT_PHASE];
			polarity_nxt = cfg_wdata[`CFG_BIT_POLARITY];
		end
	end
	// Changing phase or polarity mid-frame is not guarded: software's duty
	always @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			host_r <= CFG_RESET[`CFG_BIT_HOST];
			phase_r <= CFG_RESET[`CFG_BIT_PHASE];
			polarity_r <= CFG_RESET[`CFG_BIT_POLARITY];
		end else begin
			host_r <= host_nxt;
			phase_r <= phase_nxt;
			polarity_r <= polarity_nxt;
		end
	end
	assign host_role_enable = host_r;
	assign clock_phase_select = phase_r;
	assign clock_polarity_select = polarity_r;
	assign sck_idle_level = polarity_r;
	// Phase 0 latches on the leading edge, phase 1 on the trailing edge
	assign sample_on_rising = phase_r ~^ polarity_r;

	// ****************************************
	// Shifter and receive status
	// ****************************************
	reg shift_empty_r;
	reg rx_empty_r;
	reg shift_empty_nxt;
	reg rx_empty_nxt;
	wire shift_clear;
	assign shift_clear = tx_load | (sck_edge & port_enable_bit);
	always @* begin
		shift_empty_nxt = shift_empty_r;
		rx_empty_nxt = rx_empty_r;
		// Clearing causes win over the idle set so no edge is missed
		if (shift_clear) begin
			shift_empty_nxt = 1'b0;
		end else if (!transfer_busy) begin
			shift_empty_nxt = 1'b1;
		end
		// Arrival wins over a read in the same cycle
		if (rx_byte_arrived) begin
			rx_empty_nxt = 1'b0;
		end else if (rx_buffer_read) begin
			rx_empty_nxt = 1'b1;
		end
	end
	always @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			shift_empty_r <= CFG_RESET[`CFG_BIT_SHIFT_EMPTY];
			rx_empty_r <= CFG_RESET[`CFG_BIT_RX_EMPTY];
		end else begin
			shift_empty_r <= shift_empty_nxt;
			rx_empty_r <= rx_empty_nxt;
		end
	end
	assign shifter_empty_flag = host_r | shift_empty_r;
	assign rx_holding_empty_flag = rx_empty_r;

	// ****************************************
	// Read value
	// ****************************************
	// Live pin bit trails the pin by the synchroniser plus this register
	reg [7:0] read_image_nxt;
	always @* begin
		read_image_nxt = 8'h00;
		read_image_nxt[`CFG_BIT_BUSY] = transfer_busy;
		read_image_nxt[`CFG_BIT_HOST] = host_r;
		read_image_nxt[`CFG_BIT_PHASE] = phase_r;
		read_image_nxt[`CFG_BIT_POLARITY] = polarity_r;
		read_image_nxt[`CFG_BIT_SELECTED] = selected_r;
		read_image_nxt[`CFG_BIT_PIN_LIVE] = nss_sync;
		read_image_nxt[`CFG_BIT_SHIFT_EMPTY] = host_r | shift_empty_r;
		read_image_nxt[`CFG_BIT_RX_EMPTY] = rx_empty_r;
	end
	always @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			cfg_rdata <= CFG_RESET;
		end else begin
			cfg_rdata <= read_image_nxt;
		end
	end

endmodule // spi_config_status

// ---- rtl/spi_config_status_regs.vh ----
// Bit positions and reset value of the SPI configuration and status register
`ifndef SPI_CONFIG_STATUS_REGS_VH
`define SPI_CONFIG_STATUS_REGS_VH
`define CFG_RESET_VALUE 8'h07
`define CFG_BIT_BUSY 7
`define CFG_BIT_HOST 6
`define CFG_BIT_PHASE 5
`define CFG_BIT_POLARITY 4
`define CFG_BIT_SELECTED 3
`define CFG_BIT_PIN_LIVE 2
`define CFG_BIT_SHIFT_EMPTY 1
`define CFG_BIT_RX_EMPTY 0
`define GLITCH_FILTER_CYCLES 2'h2
`define PIN_SYNC_IDLE 2'h1
`endif

// ---- sim/spi_config_status_properties.sv ----
// Assertion checker for the SPI configuration and status register
`timescale 1ns/1ps
module spi_config_status_properties(input wire clk, input wire reset_n, input wire cfg_write,
	input wire [7:0] cfg_wdata, input wire [7:0] cfg_rdata, input wire transfer_busy,
	input wire tx_load, input wire rx_byte_arrived, input wire rx_buffer_read,
	input wire slave_select_input, input wire host_role_enable, input wire clock_phase_select,
	input wire clock_polarity_select, input wire sck_idle_level, input wire sample_on_rising,
	input wire selected_flag, input wire shifter_empty_flag, input wire rx_holding_empty_flag);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_low; !slave_select_input[*8]; endsequence
	sequence s_high; slave_select_input[*8]; endsequence
	a_busy_image: assert property (cfg_rdata[7] == $past(transfer_busy)) else $error("busy");
	a_host_write: assert property (cfg_write |=> host_role_enable == $past(cfg_wdata[6]))
		else $error("host bit");
	a_idle_level: assert property (cfg_write |=> sck_idle_level == $past(cfg_wdata[4])) else $error("idle");
	a_sel_set: assert property (s_low |-> selected_flag) else $error("sel set");
	a_sel_clear: assert property (s_high |-> !selected_flag) else $error("sel clear");
	// Long window rides out the reset values of the pin synchroniser
	a_live_pin: assert property ($stable(slave_select_input)[*6] |->
		cfg_rdata[2] == slave_select_input) else $error("live pin");
	a_tx_clear: assert property (tx_load && !host_role_enable |=> !shifter_empty_flag)
		else $error("tx load");
	a_host_empty: assert property (host_role_enable |-> shifter_empty_flag) else $error("host");
	a_edge_pick: assert property (cfg_write |=> sample_on_rising == ($past(cfg_wdata[5]) == $past(cfg_wdata[4])))
		else $error("edge");
	a_rx_arrive: assert property (rx_byte_arrived |=> !rx_holding_empty_flag)
		else $error("rx arrive");
endmodule // spi_config_status_properties
bind spi_config_status spi_config_status_properties chk(.*);

// ---- sim/spi_config_status_test.sv ----
// Self-checking bench for the SPI configuration and status register
`timescale 1ns/1ps
module spi_config_status_test;
	logic clk = 0, reset_n = 0, cfg_write = 0, port_enable_bit = 0, transfer_busy = 0;
	logic tx_load = 0, rx_byte_arrived = 0, rx_buffer_read = 0;
	logic [7:0] cfg_wdata = 8'h00;
	wire [7:0] cfg_rdata;
	wire slave_select_input, sck_pin, host_role_enable, clock_phase_select, clock_polarity_select;
	wire sck_idle_level, sample_on_rising, selected_flag, shifter_empty_flag, rx_holding_empty_flag;
	int bad_count = 0, check_count = 0;
	spi_config_status uut(.*);
	spi_far_side far(.pol(clock_polarity_select), .sel_n(slave_select_input), .sck(sck_pin));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] d);
		cfg_write <= 1'b1;
		cfg_wdata <= d;
		tick(1);
		cfg_write <= 1'b0;
		tick(3);
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial forever #12.5 clk = ~clk;
	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end
	initial begin
		tick(8);
		reset_n <= 1'b1;
		tick(6);
		chk("image", 8'h07, cfg_rdata);
		wr(8'hFF);
		chk("image", 8'h77, cfg_rdata);
		chk("config", 8'h07, {5'h0, host_role_enable, clock_phase_select, clock_polarity_select});
		chk("edge", 8'h03, {6'h0, sck_idle_level, sample_on_rising});
		wr(8'h20);
		chk("edge", 8'h00, {6'h0, sck_idle_level, sample_on_rising});
		wr(8'h00);
		far.glitch();
		tick(8);
		chk("selected", 8'h00, {7'h0, selected_flag});
		port_enable_bit <= 1'b1;
		transfer_busy <= 1'b1;
		fork far.frame(16); join_none
		tick(20);
		chk("image", 8'h89, cfg_rdata);
		tick(80);
		transfer_busy <= 1'b0;
		tick(6);
		chk("image", 8'h07, cfg_rdata);
		tx_load <= 1'b1;
		tick(1);
		chk("shifter empty", 8'h00, {7'h0, shifter_empty_flag});
		tx_load <= 1'b0;
		tick(2);
		chk("shifter empty", 8'h01, {7'h0, shifter_empty_flag});
		rx_byte_arrived <= 1'b1;
		rx_buffer_read <= 1'b1;
		tick(1);
		chk("rx empty", 8'h00, {7'h0, rx_holding_empty_flag});
		rx_byte_arrived <= 1'b0;
		tick(1);
		chk("rx empty", 8'h01, {7'h0, rx_holding_empty_flag});
		rx_buffer_read <= 1'b0;
		tick(2);
		end_of_test();
	end
endmodule // spi_config_status_test

// ---- sim/spi_far_side.sv ----
// Far-side SPI master model
`timescale 1ns/1ps
module spi_far_side(input wire logic pol, output logic sel_n, output logic sck);
	initial begin
		sel_n = 1'b1;
		sck = 1'b0;
	end
	// Clock starts low, is set to the idle level when a frame begins and stays there after it
	task automatic frame(input int edges);
		sck = pol;
		sel_n = 1'b0;
		#300;
		repeat (edges) #100 sck = ~sck;
		#300;
		sel_n = 1'b1;
	endtask
	task automatic glitch();
		sel_n = 1'b0;
		#25 sel_n = 1'b1;
	endtask
endmodule // spi_far_side
